// *** bench/pbe_term_model.sv ***
// line-side terminal model: loops the port's transmit stream back or drives a fixed bit
`timescale 1ns/1ps
module pbe_term_model (
	input  wire logic i_core_clk,
	input  wire logic i_loop_en,
	input  wire logic i_drive_en,
	input  wire logic i_drive_bit,
	input  wire logic i_flip,
	input  wire logic i_tx_bit,
	input  wire logic i_tx_valid,
	output logic      o_rx_bit,
	output logic      o_rx_valid
);
	logic flip_r; // one corrupted bit waiting for the next looped bit
	initial begin
		o_rx_bit = 1'h0;
		o_rx_valid = 1'h0;
		flip_r = 1'h0;
	end
	// a released line toggles so that a stale bit never passes as data
	always @(posedge i_core_clk) begin
		if (i_loop_en && i_tx_valid) begin
			o_rx_bit   <= i_tx_bit ^ flip_r;
			o_rx_valid <= 1'h1;
			flip_r     <= i_flip;
		end else if (i_drive_en) begin
			// fixed level from the far end
			o_rx_bit   <= i_drive_bit;
			o_rx_valid <= 1'h1;
			flip_r     <= flip_r | i_flip;
		end else begin
			o_rx_bit   <= ~o_rx_bit;
			o_rx_valid <= 1'h0;
			flip_r     <= flip_r | i_flip;
		end
	end
endmodule : pbe_term_model

// *** bench/tb_top.sv ***
// self-checking bench for the port bit error test engine
`timescale 1ns/1ps
module tb_top;
	import pbe_pkg::*;
	// row: port, pattern, check kind (0 recurrence, 1 zero run, 2 alternate), taps
	typedef struct {
		pbe_port_t port;
		pbe_pat_t  pat;
		int        kind;
		int        ta;
		int        tc;
	} pbe_row_t;
	pbe_row_t rows[5] = '{
		'{PBE_PORT_E1, PBE_PAT_PRBS15, 0, PBE_P15_TAP_A, PBE_P15_TAP_B},
		'{PBE_PORT_T1, PBE_PAT_PRBS15, 1, 0, 0},
		'{PBE_PORT_E3T3, PBE_PAT_PRBS23, 0, PBE_P23_TAP_A, PBE_P23_TAP_B},
		'{PBE_PORT_E3T3, PBE_PAT_ALT, 2, 0, 0},
		'{PBE_PORT_E3T3, PBE_PAT_PRBS15, 0, PBE_P15_TAP_A, PBE_P15_TAP_B}};
	logic                  clk = 1'h0;
	logic                  rst = 1'h1;
	pbe_port_t             port = PBE_PORT_E1;
	pbe_mode_t             mode = PBE_MODE_NORMAL;
	pbe_pat_t              pat = PBE_PAT_PRBS15;
	logic                  start = 1'h0;
	logic [PBE_RATE_W:0]   rate = '0;
	logic                  single = 1'h0;
	logic                  utx_bit = 1'h0;
	logic                  utx_vld = 1'h0;
	logic                  map_rdy = 1'h1;
	logic                  rx_bit, rx_vld, utx_rdy, map_bit, map_vld;
	logic                  ltx_bit, ltx_vld, urx_bit, urx_vld, bit_err, sync;
	logic [PBE_ERR_W-1:0]  err_cnt;
	logic [PBE_TIME_W-1:0] ms;
	logic                  loop_en = 1'h0; // far end loops the pattern back
	logic                  drv_en = 1'h0;  // far end sends a fixed level
	logic                  drv_bit = 1'h0;
	logic                  flip = 1'h0;    // far end corrupts one bit
	logic                  collect = 1'h0; // capture transmitted bits
	logic                  q[$];
	logic [31:0]           base;
	int                    n_errors = 0;
	int                    checked = 0;
	int                    n_bits = 0;
	int                    n_pulses = 0;
	int                    n_map = 0;
	// 200 MHz core clock
	initial begin
		forever #2.5 clk = ~clk;
	end
	pbe_engine dut_u (
		.i_core_clk(clk), .i_sys_rst(rst), .i_port_type(port), .i_mode(mode),
		.i_pattern(pat), .i_test_start(start), .i_inject_rate(rate),
		.i_inject_single(single), .i_user_tx_bit(utx_bit), .i_user_tx_valid(utx_vld),
		.i_line_rx_bit(rx_bit), .i_line_rx_valid(rx_vld), .o_user_tx_ready(utx_rdy),
		.o_mapper_tx_bit(map_bit), .o_mapper_tx_valid(map_vld),
		.i_mapper_tx_ready(map_rdy), .o_line_tx_bit(ltx_bit), .o_line_tx_valid(ltx_vld),
		.o_user_rx_bit(urx_bit), .o_user_rx_valid(urx_vld), .o_bit_error(bit_err),
		.o_err_count(err_cnt), .o_elapsed_ms(ms), .o_sync(sync));
	pbe_term_model term_u (
		.i_core_clk(clk), .i_loop_en(loop_en), .i_drive_en(drv_en), .i_drive_bit(drv_bit),
		.i_flip(flip), .i_tx_bit(ltx_bit), .i_tx_valid(ltx_vld),
		.o_rx_bit(rx_bit), .o_rx_valid(rx_vld));
	// counters sampled mid-cycle, away from the edge that updates them
	always @(negedge clk) begin
		if (ltx_vld === 1'h1) begin
			n_bits++;
			if (collect) q.push_back(ltx_bit);
		end
		if (bit_err === 1'h1) n_pulses++;
		if (map_vld === 1'h1) n_map++;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	task automatic cmp_bit(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_bit
	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_word
	// start pin held three edges so the synchroniser sees one rising edge
	task automatic start_test();
		start <= 1'h1;
		cyc(3);
		start <= 1'h0;
		cyc(8);
	endtask : start_test
	task automatic inj_single();
		single <= 1'h1;
		cyc(1);
		single <= 1'h0;
		cyc(1);
	endtask : inj_single
	// error total taken mid-cycle, pulse counter cleared on the edge
	task automatic snap();
		@(negedge clk);
		base = err_cnt;
		@(posedge clk);
		n_pulses = 0;
		n_bits = 0;
	endtask : snap
	task automatic final_report();
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : final_report
	// watchdog well beyond the expected run of about 24000 cycles
	initial begin
		cyc(60000);
		n_errors++;
		final_report();
	end
	initial begin
		int run;
		int mx;
		int d;
		int e;
		cyc(16);
		@(negedge clk);
		cmp_word(err_cnt, 32'h0);
		cmp_bit(sync, 1'h0);
		@(posedge clk);
		rst <= 1'h0;
		cyc(4);
		mode <= PBE_MODE_BERT;
		loop_en <= 1'h1;
		// one pass per row of port and pattern, looped back by the far end
		foreach (rows[i]) begin
			port <= rows[i].port;
			pat <= rows[i].pat;
			start_test();
			cyc(100);
			q.delete();
			collect = 1'h1;
			cyc(300);
			collect = 1'h0;
			@(negedge clk);
			mx = 0;
			run = 0;
			for (int k = 1; k < q.size(); k++) begin
				run = q[k] ? 0 : run + 1;
				mx = (run > mx) ? run : mx;
				if (rows[i].kind == 0 && k >= rows[i].ta)
					cmp_bit(q[k], q[k-rows[i].ta] ^ q[k-rows[i].tc]);
				if (rows[i].kind == 2)
					cmp_bit(q[k], ~q[k-1]);
			end
			if (rows[i].kind == 1)
				cmp_bit(mx <= PBE_QUASI_RANDOM_TEST_SIGNAL_ZMAX && mx > 0, 1'h1);
			cmp_bit(sync, 1'h1);
			cmp_word(err_cnt, 32'h0);
			$display("test pattern row %0d done", i);
			@(posedge clk);
		end
		// one bit corrupted on the return path
		snap();
		flip <= 1'h1;
		cyc(1);
		flip <= 1'h0;
		cyc(20);
		@(negedge clk);
		cmp_word(err_cnt, base + 32'h1);
		cmp_word(32'(n_pulses), 32'h1);
		// two single injections back to back
		snap();
		inj_single();
		inj_single();
		cyc(20);
		@(negedge clk);
		cmp_word(err_cnt, base + 32'h2);
		$display("test single errors done");
		// every calibrated rate over a 3000 cycle window
		for (int n = 1; n <= 7; n++) begin
			snap();
			rate <= 4'(n);
			cyc(3000);
			rate <= '0;
			cyc(20);
			@(negedge clk);
			d = int'(err_cnt - base);
			e = n_bits / (10 ** n);
			cmp_bit(d >= e - 2 && d <= e + 2, 1'h1);
			@(posedge clk);
		end
		start_test();
		@(negedge clk);
		cmp_word(err_cnt, 32'h0);
		cmp_word(ms, 32'h0);
		$display("test rates and restart done");
		// injection refused on an E1 port
		@(posedge clk);
		port <= PBE_PORT_E1;
		start_test();
		cyc(100);
		snap();
		inj_single();
		rate <= 4'h1;
		cyc(200);
		rate <= '0;
		@(negedge clk);
		cmp_word(err_cnt, base);
		cmp_bit(sync, 1'h1);
		// loopback steering with opposite levels at each end
		@(posedge clk);
		loop_en <= 1'h0;
		drv_en <= 1'h1;
		utx_vld <= 1'h1;
		for (int b = 0; b < 2; b++) begin
			mode <= PBE_MODE_LOCAL_LB;
			utx_bit <= b[0];
			drv_bit <= ~b[0];
			cyc(20);
			@(negedge clk);
			cmp_bit(urx_bit, b[0]);
			cmp_bit(map_bit, b[0]);
			@(posedge clk);
			mode <= PBE_MODE_REMOTE_LB;
			cyc(20);
			@(negedge clk);
			cmp_bit(ltx_bit, ~b[0]);
			cmp_bit(urx_vld, 1'h0);
			@(posedge clk);
			mode <= PBE_MODE_REMOTE_LB_AIS;
			cyc(20);
			@(negedge clk);
			cmp_bit(ltx_bit, ~b[0]);
			cmp_bit(urx_bit, 1'h1);
			cmp_bit(urx_vld, 1'h1);
			@(posedge clk);
		end
		$display("test loopbacks done");
		// buffer filled against a stalled mapper, then drained
		mode <= PBE_MODE_LOCAL_LB;
		cyc(10);
		map_rdy <= 1'h0;
		cyc(20);
		@(negedge clk);
		cmp_bit(utx_rdy, 1'h0);
		@(posedge clk);
		utx_vld <= 1'h0;
		cyc(4);
		n_map = 0;
		map_rdy <= 1'h1;
		cyc(30);
		@(negedge clk);
		cmp_word(32'(n_map), 32'(PBE_FIFO_DEPTH));
		cmp_bit(utx_rdy, 1'h1);
		// reset in mid-run
		@(posedge clk);
		rst <= 1'h1;
		cyc(2);
		@(negedge clk);
		cmp_word(err_cnt, 32'h0);
		cmp_bit(sync, 1'h0);
		cmp_bit(map_vld, 1'h0);
		$display("test buffer and reset done");
		final_report();
	end
endmodule : tb_top

// *** logic/pbe_engine.sv ***
// top of the port bit error test engine with loopback steering
// Behaviour
// - E1 ports send 2^15-1 pseudo-random pattern
// - T1 ports send quasi-random 2^20-1 pattern
// - E3/T3 selects prbs15, prbs23 or alternating
// - test pattern replaces transmit data input
// - receive bits compared, mismatches flagged while in sync
// - running error total readable by user
// - elapsed time readable with matching errors
// - evaluator sync status is exposed
// - E3/T3 calibrated error insertion, 1e-1..1e-7
// - E3/T3 single error insertion on request
// - inserted errors counted like ordinary errors
// - remote loop with all-ones toward local user
// - local loop returns user data, still mapped
// - remote loop returns line data, user ignored
`timescale 1ns/1ps
module pbe_engine
	import pbe_pkg::*;
(
	input  wire logic                      i_core_clk,
	input  wire logic                      i_sys_rst,
	input  pbe_pkg::pbe_port_t             i_port_type,
	input  pbe_pkg::pbe_mode_t             i_mode,
	input  pbe_pkg::pbe_pat_t              i_pattern,
	input  wire logic                      i_test_start,
	input  wire logic [PBE_RATE_W:0]       i_inject_rate,
	input  wire logic                      i_inject_single,
	input  wire logic                      i_user_tx_bit,
	input  wire logic                      i_user_tx_valid,
	input  wire logic                      i_line_rx_bit,
	input  wire logic                      i_line_rx_valid,
	output logic                           o_user_tx_ready,
	output logic                           o_mapper_tx_bit,
	output logic                           o_mapper_tx_valid,
	input  wire logic                      i_mapper_tx_ready,
	output logic                           o_line_tx_bit,
	output logic                           o_line_tx_valid,
	output logic                           o_user_rx_bit,
	output logic                           o_user_rx_valid,
	output logic                           o_bit_error,
	output logic [PBE_ERR_W-1:0]           o_err_count,
	output logic [PBE_TIME_W-1:0]          o_elapsed_ms,
	output logic                           o_sync
);
	import pbe_pkg::*;

	// line, user, start and single inject pins are synchronised by two flops before any logic reads them
	logic [1:0] rxb_s_r;   // line receive bit sync
	logic [1:0] rxv_s_r;   // line receive valid sync
	logic [1:0] txb_s_r;   // user transmit bit sync
	logic [1:0] txv_s_r;   // user transmit valid sync
	logic [1:0] ss_s_r;    // single inject request sync
	logic [1:0] st_s_r;    // test start sync
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			rxb_s_r <= '0;
			rxv_s_r <= '0;
			txb_s_r <= '0;
			txv_s_r <= '0;
			ss_s_r  <= '0;
			st_s_r  <= '0;
		end else begin
			rxb_s_r <= {rxb_s_r[0], i_line_rx_bit};
			rxv_s_r <= {rxv_s_r[0], i_line_rx_valid};
			txb_s_r <= {txb_s_r[0], i_user_tx_bit};
			txv_s_r <= {txv_s_r[0], i_user_tx_valid};
			ss_s_r  <= {ss_s_r[0], i_inject_single};
			st_s_r  <= {st_s_r[0], i_test_start};
		end
	end
	logic rx_bit;
	logic rx_val;
	logic tx_bit;
	logic tx_val;
	assign rx_bit = rxb_s_r[1];
	assign rx_val = rxv_s_r[1];
	assign tx_bit = txb_s_r[1];
	assign tx_val = txv_s_r[1];

	// edge detect on the synchronised start and single inject levels
	logic st_d_r;
	logic ss_d_r;
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			st_d_r <= 1'b0;
			ss_d_r <= 1'b0;
		end else begin
			st_d_r <= st_s_r[1];
			ss_d_r <= ss_s_r[1];
		end
	end
	logic start_p;
	logic single_p;
	logic bert_on;
	logic is_e3;
	assign start_p  = st_s_r[1] & ~st_d_r;
	assign single_p = ss_s_r[1] & ~ss_d_r;
	assign bert_on  = (i_mode == PBE_MODE_BERT);
	assign is_e3    = (i_port_type == PBE_PORT_E3T3);

	// fifo feeds the mapper; the generator stalls when it fills
	logic fifo_in_bit;
	logic fifo_in_val;
	logic fifo_in_rdy;
	logic gen_bit;
	logic gen_step;
	logic inj_now;
	assign gen_step = bert_on && fifo_in_rdy;
	pbe_prbs u_gen (
		.i_core_clk (i_core_clk),
		.i_sys_rst  (i_sys_rst),
		.i_restart  (start_p),
		.i_step     (gen_step),
		.i_port     (i_port_type),
		.i_pat      (i_pattern),
		.i_track    (1'b0),
		.i_track_bit(1'b0),
		.o_bit      (gen_bit)
	);

	// error insertion: calibrated decade divider plus a single request
	logic [PBE_DECADE_W-1:0] inj_cnt_r;    // bits since last insertion
	logic [PBE_DECADE_W-1:0] inj_lim;      // decade limit minus one
	logic                    single_pend_r; // single request awaiting a bit
	always_comb begin
		unique case (i_inject_rate)
			4'h1:    inj_lim = 24'h000009;
			4'h2:    inj_lim = 24'h000063;
			4'h3:    inj_lim = 24'h0003E7;
			4'h4:    inj_lim = 24'h00270F;
			4'h5:    inj_lim = 24'h01869F;
			4'h6:    inj_lim = 24'h0F423F;
			4'h7:    inj_lim = 24'h98967F;
			default: inj_lim = 24'h000000;   // zero means rate insertion off
		endcase
	end
	logic rate_hit;
	assign rate_hit = is_e3 && (inj_lim != '0) && (inj_cnt_r == inj_lim);
	assign inj_now  = gen_step && is_e3 && (rate_hit || single_pend_r);
	// decade counter advances once per transmitted test bit
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst || start_p) begin
			inj_cnt_r <= '0;
		end else if (gen_step) begin
			inj_cnt_r <= (inj_cnt_r >= inj_lim) ? '0 : inj_cnt_r + 24'h000001;
		end
	end
	// single request waits for the next bit; a new request wins over the consume
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			single_pend_r <= 1'b0;
		end else if (single_p && is_e3) begin
			single_pend_r <= 1'b1;
		end else if (inj_now) begin
			single_pend_r <= 1'b0;
		end
	end

	// transmit source: pattern in test, line data in remote loop, else user
	always_comb begin
		fifo_in_bit = tx_bit;
		fifo_in_val = tx_val;
		if (bert_on) begin
			fifo_in_bit = gen_bit ^ inj_now;
			fifo_in_val = 1'b1;
		end else if (i_mode == PBE_MODE_REMOTE_LB || i_mode == PBE_MODE_REMOTE_LB_AIS) begin
			fifo_in_bit = rx_bit;
			fifo_in_val = rx_val;
		end
	end
	logic fifo_out_bit;
	logic fifo_out_val;
	pbe_fifo #(
		.WIDTH (1),
		.DEPTH (PBE_FIFO_DEPTH)
	) u_fifo (
		.i_core_clk (i_core_clk),
		.i_sys_rst  (i_sys_rst),
		.i_wr_data  (fifo_in_bit),
		.i_wr_valid (fifo_in_val),
		.o_wr_ready (fifo_in_rdy),
		.o_rd_data  (fifo_out_bit),
		.o_rd_valid (fifo_out_val),
		.i_rd_ready (i_mapper_tx_ready)
	);

	// registered mapper and line outputs plus user receive steering
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			o_mapper_tx_bit   <= 1'b0;
			o_mapper_tx_valid <= 1'b0;
			o_line_tx_bit     <= 1'b0;
			o_line_tx_valid   <= 1'b0;
			o_user_rx_bit     <= 1'b0;
			o_user_rx_valid   <= 1'b0;
			o_user_tx_ready   <= 1'b0;
		end else begin
			// bit gated by valid so an empty buffer never shows unwritten storage
			o_mapper_tx_bit   <= fifo_out_bit & fifo_out_val;
			o_mapper_tx_valid <= fifo_out_val && i_mapper_tx_ready;
			o_line_tx_bit     <= fifo_out_bit & fifo_out_val;
			o_line_tx_valid   <= fifo_out_val && i_mapper_tx_ready;
			// user port refused in test mode, stalled by a full fifo
			o_user_tx_ready   <= fifo_in_rdy && !bert_on;
			unique case (i_mode)
				PBE_MODE_LOCAL_LB: begin
					o_user_rx_bit   <= tx_bit;
					o_user_rx_valid <= tx_val;
				end
				PBE_MODE_REMOTE_LB_AIS: begin
					o_user_rx_bit   <= 1'b1;
					o_user_rx_valid <= 1'b1;
				end
				PBE_MODE_REMOTE_LB: begin
					o_user_rx_bit   <= 1'b0;
					o_user_rx_valid <= 1'b0;
				end
				default: begin
					o_user_rx_bit   <= rx_bit;
					o_user_rx_valid <= rx_val;
				end
			endcase
		end
	end

	// evaluator: a local reference generator tracks the received stream
	logic ref_bit;
	logic ref_step;
	logic ref_load;
	logic ref_track;
	logic mism;
	assign ref_step = bert_on && rx_val;
	assign mism     = ref_step && (rx_bit != ref_bit);
	// while unlocked the reference shifts in received bits, so stale bits still in
	// the loop after a start cannot leave it out of phase; locked, it runs free
	assign ref_load  = start_p;
	assign ref_track = !o_sync;
	pbe_prbs u_ref (
		.i_core_clk (i_core_clk),
		.i_sys_rst  (i_sys_rst),
		.i_restart  (ref_load),
		.i_step     (ref_step),
		.i_port     (i_port_type),
		.i_pat      (i_pattern),
		.i_track    (ref_track),
		.i_track_bit(rx_bit),
		.o_bit      (ref_bit)
	);
	// sync state: lock after a run of good bits, drop on too many errors
	logic [5:0] good_r;   // consecutive good bits
	logic [5:0] win_r;    // window bit counter
	logic [5:0] bad_r;    // errors in window
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst || start_p || !bert_on) begin
			good_r <= '0;
			win_r  <= '0;
			bad_r  <= '0;
			o_sync <= 1'b0;
		end else if (ref_step) begin
			good_r <= mism ? 6'h00 : (good_r == PBE_SYNC_GOOD ? good_r : good_r + 6'h01);
			win_r  <= win_r + 6'h01;
			if (!o_sync) begin
				o_sync <= (!mism && good_r == PBE_SYNC_GOOD - 6'h01);
				bad_r  <= '0;
			end else if (bad_r + 6'(mism) >= PBE_SYNC_BAD) begin
				o_sync <= 1'b0;
				bad_r  <= '0;
			end else if (win_r == PBE_SYNC_WIN) begin
				bad_r  <= 6'(mism);
			end else begin
				bad_r  <= bad_r + 6'(mism);
			end
		end
	end

	// error flag and totals; errors only counted while locked, time counted whenever in test
	logic [31:0] tick_r;  // millisecond prescaler
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst || start_p) begin
			o_bit_error  <= 1'b0;
			o_err_count  <= '0;
			o_elapsed_ms <= '0;
			tick_r       <= '0;
		end else begin
			o_bit_error <= mism && o_sync;
			if (mism && o_sync && o_err_count != '1) begin
				o_err_count <= o_err_count + 32'h00000001;
			end
			if (bert_on) begin
				if (tick_r == 32'(PBE_TICK_CYC - 1)) begin
					tick_r       <= '0;
					o_elapsed_ms <= o_elapsed_ms + 32'h00000001;
				end else begin
					tick_r <= tick_r + 32'h00000001;
				end
			end
		end
	end

	a_start_clears: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		start_p |=> (o_err_count == '0 && o_elapsed_ms == '0)) else $error("start no clear");
	a_err_counts: assert property (@(posedge i_core_clk) disable iff (i_sys_rst || start_p)
		(mism && o_sync && o_err_count != '1) |=> o_err_count == $past(o_err_count) + 1)
		else $error("error not counted");
	a_err_flag: assert property (@(posedge i_core_clk) disable iff (i_sys_rst || start_p)
		(mism && o_sync) |=> o_bit_error) else $error("error flag missing");
	a_ais_out: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		(i_mode == PBE_MODE_REMOTE_LB_AIS) |=> (o_user_rx_bit && o_user_rx_valid))
		else $error("ais missing");
	a_local_loop: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		(i_mode == PBE_MODE_LOCAL_LB) |=> o_user_rx_bit == $past(tx_bit))
		else $error("local loop wrong");
	a_pattern_in: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		(gen_step && !inj_now) |-> fifo_in_bit == gen_bit) else $error("pattern not fed");
	a_inject_e1: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		!is_e3 |-> !inj_now) else $error("inject on E1/T1");
	a_single_once: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		(inj_now && single_pend_r && !single_p) |=> !single_pend_r)
		else $error("single inject stuck");
	a_sync_drop: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		!bert_on |=> !o_sync) else $error("sync outside test");
	a_time_tick: assert property (@(posedge i_core_clk) disable iff (i_sys_rst || start_p)
		(bert_on && tick_r == 32'(PBE_TICK_CYC - 1)) |=> o_elapsed_ms == $past(o_elapsed_ms) + 1)
		else $error("time not advanced");
endmodule : pbe_engine

// *** logic/pbe_fifo.sv ***
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
module pbe_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 8
) (
	input  wire logic             i_core_clk,
	input  wire logic             i_sys_rst,
	input  wire logic [WIDTH-1:0] i_wr_data,
	input  wire logic             i_wr_valid,
	output logic                  o_wr_ready,
	output logic      [WIDTH-1:0] o_rd_data,
	output logic                  o_rd_valid,
	input  wire logic             i_rd_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];   // storage
	logic [AW-1:0]    wr_ptr_r;        // write index
	logic [AW-1:0]    rd_ptr_r;        // read index
	logic [AW:0]      count_r;         // fill level
	logic             push;
	logic             pop;
	assign push       = i_wr_valid && o_wr_ready;
	assign pop        = o_rd_valid && i_rd_ready;
	// full compare at the level's own width; a pointer-wide depth would wrap to zero
	assign o_wr_ready = (count_r != (AW+1)'(DEPTH));
	assign o_rd_valid = (count_r != '0);
	assign o_rd_data  = mem_r[rd_ptr_r];
	// storage write, no reset needed on data
	always_ff @(posedge i_core_clk) begin
		if (push) begin
			mem_r[wr_ptr_r] <= i_wr_data;
		end
	end
	// pointers and level
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + AW'(1);
			end
			if (pop) begin
				rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + AW'(1);
			end
			count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
	// level never passes depth
	a_fifo_level: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		count_r <= (AW+1)'(DEPTH)) else $error("fifo level above depth");
endmodule : pbe_fifo

// *** logic/pbe_pkg.sv ***
// package of constants and types for the port bit error test engine
package pbe_pkg;
	// port flavour
	typedef enum logic [1:0] {
		PBE_PORT_E1,
		PBE_PORT_T1,
		PBE_PORT_E3T3
	} pbe_port_t;
	// pattern choice on E3/T3 ports
	typedef enum logic [1:0] {
		PBE_PAT_PRBS15,
		PBE_PAT_PRBS23,
		PBE_PAT_ALT
	} pbe_pat_t;
	// port operating mode
	typedef enum logic [2:0] {
		PBE_MODE_NORMAL,
		PBE_MODE_BERT,
		PBE_MODE_LOCAL_LB,
		PBE_MODE_REMOTE_LB,
		PBE_MODE_REMOTE_LB_AIS
	} pbe_mode_t;
	// register widths
	localparam int PBE_LFSR_W   = 23;
	localparam int PBE_ERR_W    = 32;
	localparam int PBE_TIME_W   = 32;
	localparam int PBE_RATE_W   = 3;
	localparam int PBE_DECADE_W = 24;
	// generator polynomial taps (bit positions, one based)
	localparam int PBE_P15_TAP_A = 15;
	localparam int PBE_P15_TAP_B = 14;
	localparam int PBE_P20_TAP_A = 20;
	localparam int PBE_P20_TAP_B = 3;
	localparam int PBE_P23_TAP_A = 23;
	localparam int PBE_P23_TAP_B = 18;
	// quasi random signal forces a one after this many zeros
	localparam int PBE_QUASI_RANDOM_TEST_SIGNAL_ZMAX = 14;
	// evaluator sync: matching bits to lock, errors in window to drop
	localparam logic [5:0] PBE_SYNC_GOOD = 6'h20;
	localparam logic [5:0] PBE_SYNC_WIN  = 6'h3F;
	localparam logic [5:0] PBE_SYNC_BAD  = 6'h08;
	// elapsed time unit: one tick per millisecond at 200 MHz
	localparam int PBE_CLK_MHZ    = 200;
	localparam int PBE_TICK_US    = 1000;
	localparam int PBE_TICK_CYC   = PBE_TICK_US * PBE_CLK_MHZ;
	// buffer depth in the transmit data path
	localparam int PBE_FIFO_DEPTH = 8;
	localparam logic [PBE_LFSR_W-1:0] PBE_SEED = 23'h7FFFFF;
endpackage : pbe_pkg

// *** logic/pbe_prbs.sv ***
// pattern generator step: prbs15, qrss20, prbs23 and alternating
`timescale 1ns/1ps
module pbe_prbs
	import pbe_pkg::*;
(
	input  wire logic                  i_core_clk,
	input  wire logic                  i_sys_rst,
	input  wire logic                  i_restart,
	input  wire logic                  i_step,
	input  pbe_pkg::pbe_port_t         i_port,
	input  pbe_pkg::pbe_pat_t          i_pat,
	input  wire logic                  i_track,
	input  wire logic                  i_track_bit,
	output logic                       o_bit
);
	import pbe_pkg::*;
	logic [PBE_LFSR_W-1:0] lfsr_r;     // shift register state
	logic [4:0]            zrun_r;     // zero run length for quasi_random_test_signal
	logic                  alt_r;      // alternating mark space state
	logic                  fb;         // feedback bit
	logic                  raw;        // raw sequence bit
	logic                  nxt_in;     // bit shifted into the register
	logic                  nxt_seen;   // bit taken as the latest sequence bit
	// feedback taps by port and pattern
	always_comb begin
		fb  = 1'b0;
		raw = 1'b0;
		if (i_port == PBE_PORT_E1 || (i_port == PBE_PORT_E3T3 && i_pat == PBE_PAT_PRBS15)) begin
			fb  = lfsr_r[PBE_P15_TAP_A-1] ^ lfsr_r[PBE_P15_TAP_B-1];
			raw = fb;
		end else if (i_port == PBE_PORT_T1) begin
			fb  = lfsr_r[PBE_P20_TAP_A-1] ^ lfsr_r[PBE_P20_TAP_B-1];
			// quasi_random_test_signal output is the bit forced high after too long a zero run
			raw = fb | (zrun_r >= 5'(PBE_QUASI_RANDOM_TEST_SIGNAL_ZMAX));
		end else if (i_pat == PBE_PAT_PRBS23) begin
			fb  = lfsr_r[PBE_P23_TAP_A-1] ^ lfsr_r[PBE_P23_TAP_B-1];
			raw = fb;
		end else begin
			fb  = 1'b0;
			raw = alt_r;
		end
	end
	assign o_bit = raw;
	// while tracking, the received stream fills the register so it phases onto the far end
	assign nxt_in   = i_track ? i_track_bit : fb;
	assign nxt_seen = i_track ? i_track_bit : raw;
	// advance the sequence once per step
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst || i_restart) begin
			lfsr_r <= PBE_SEED;
			zrun_r <= '0;
			alt_r  <= 1'b0;
		end else if (i_step) begin
			lfsr_r <= {lfsr_r[PBE_LFSR_W-2:0], nxt_in};
			zrun_r <= nxt_seen ? 5'h00 : zrun_r + 5'h01;
			alt_r  <= i_track ? ~i_track_bit : ~alt_r;
		end
	end
endmodule : pbe_prbs
